//--- hall_field_readout.sv
// hall field readout: result registers, cordic strength and serial register port
// Function
// R1: pixel one z field readable, read-only, 16 bits at address 0x111.
// R2: pixel zero z field readable, read-only, 16 bits at address 0x112.
// R3: pixel one x field readable, read-only, 16 bits at address 0x113.
// R4: pixel zero x field readable, read-only, 16 bits at address 0x114.
// R5: absolute mode strength is 0.82338 times magnitude of pixel one z and x.
// R6: differential mode strength is 0.82338 times magnitude of pixel differences.
// R7: cordic field strength readable, read-only, 16 bits at address 0x120.
// R8: host may compare strength to its own limits for weak or lost magnet.
// R9: host reaches registers over four-wire serial link; device is the peripheral.
// R10: all five results update together once per conversion.
`default_nettype none
module hall_field_readout
  import hfr_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic SPI_SCLK,
  input wire logic SPI_CS_N,
  input wire logic SPI_MOSI,
  output logic SPI_MISO,
  output logic SPI_MISO_OE_N,
  input wire logic SAMPLE_VALID,
  input wire logic [15:0] Z_PIXEL_ZERO,
  input wire logic [15:0] X_PIXEL_ZERO,
  input wire logic [15:0] Z_PIXEL_ONE,
  input wire logic [15:0] X_PIXEL_ONE,
  input wire logic DIFFERENTIAL_SELECT,
  output logic RESULT_UPDATE
);
  localparam int W = HFR_CORDIC_W;

  function automatic logic signed [W-1:0] ext(input logic [15:0] v);
    ext = {{(W - 16){v[15]}}, v};
  endfunction

  // ------------------------------------------------------------
  // conversion capture and commit
  // ------------------------------------------------------------
  logic [15:0] pz0_ff, px0_ff, pz1_ff, px1_ff, nxt_pz0, nxt_px0, nxt_pz1, nxt_px1;
  logic pdiff_ff, nxt_pdiff, start_ff, nxt_start, upd_ff, nxt_upd;
  logic [15:0] z1_ff, z0_ff, x1_ff, x0_ff, mag_ff;
  logic [15:0] nxt_z1, nxt_z0, nxt_x1, nxt_x0, nxt_mag;
  logic signed [W-1:0] op_x, op_y;
  logic cor_idle, cor_done, accept;
  logic [15:0] cor_mag;

  always_comb begin
    // a new sample is dropped while a conversion is in flight
    accept = SAMPLE_VALID && cor_idle && !start_ff;
    nxt_pz0 = pz0_ff;
    nxt_px0 = px0_ff;
    nxt_pz1 = pz1_ff;
    nxt_px1 = px1_ff;
    nxt_pdiff = pdiff_ff;
    nxt_start = accept;
    if (accept) begin
      nxt_pz0 = Z_PIXEL_ZERO;
      nxt_px0 = X_PIXEL_ZERO;
      nxt_pz1 = Z_PIXEL_ONE;
      nxt_px1 = X_PIXEL_ONE;
      nxt_pdiff = DIFFERENTIAL_SELECT;
    end
    if (pdiff_ff) begin
      op_x = ext(px0_ff) - ext(px1_ff); // R6
      op_y = ext(pz0_ff) - ext(pz1_ff); // R6
    end else begin
      op_x = ext(px1_ff); // R5
      op_y = ext(pz1_ff); // R5
    end
    nxt_upd = cor_done;
    nxt_z1 = z1_ff;
    nxt_z0 = z0_ff;
    nxt_x1 = x1_ff;
    nxt_x0 = x0_ff;
    nxt_mag = mag_ff;
    if (cor_done) begin
      // raw values and strength land in one edge
      nxt_z1 = pz1_ff; // R10
      nxt_z0 = pz0_ff; // R10
      nxt_x1 = px1_ff; // R10
      nxt_x0 = px0_ff; // R10
      nxt_mag = cor_mag; // R7 R10
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pz0_ff <= HFR_RESULT_RST;
      px0_ff <= HFR_RESULT_RST;
      pz1_ff <= HFR_RESULT_RST;
      px1_ff <= HFR_RESULT_RST;
      pdiff_ff <= 1'b0;
      start_ff <= 1'b0;
      upd_ff <= 1'b0;
      z1_ff <= HFR_RESULT_RST;
      z0_ff <= HFR_RESULT_RST;
      x1_ff <= HFR_RESULT_RST;
      x0_ff <= HFR_RESULT_RST;
      mag_ff <= HFR_RESULT_RST;
    end else begin
      pz0_ff <= nxt_pz0;
      px0_ff <= nxt_px0;
      pz1_ff <= nxt_pz1;
      px1_ff <= nxt_px1;
      pdiff_ff <= nxt_pdiff;
      start_ff <= nxt_start;
      upd_ff <= nxt_upd;
      z1_ff <= nxt_z1;
      z0_ff <= nxt_z0;
      x1_ff <= nxt_x1;
      x0_ff <= nxt_x0;
      mag_ff <= nxt_mag;
    end
  end

  hfr_cordic #(
    .W(W),
    .ITER(HFR_CORDIC_ITER)
  ) u_cordic (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .start(start_ff),
    .vec_x(op_x),
    .vec_y(op_y),
    .idle(cor_idle),
    .done(cor_done),
    .mag(cor_mag)
  );

  assign RESULT_UPDATE = upd_ff;

  // ------------------------------------------------------------
  // serial register port, mode 0
  // ------------------------------------------------------------
  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff, cs_s1_ff, cs_s2_ff, mosi_s1_ff, mosi_s2_ff;
  logic [HFR_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [HFR_CMD_W-1:0] cmd_ff, nxt_cmd;
  logic [15:0] tx_ff, nxt_tx, rd_data;
  logic rd_ff, nxt_rd, miso_ff, nxt_miso, oe_n_ff, nxt_oe_n, sclk_rise, sclk_fall;

  // unmapped addresses read as zero; registers are read-only
  always_comb begin
    unique case (nxt_cmd[HFR_ADDR_LSB +: HFR_ADDR_W])
      HFR_OFS_Z_PIXEL_ONE: rd_data = z1_ff; // R1
      HFR_OFS_Z_PIXEL_ZERO: rd_data = z0_ff; // R2
      HFR_OFS_X_PIXEL_ONE: rd_data = x1_ff; // R3
      HFR_OFS_X_PIXEL_ZERO: rd_data = x0_ff; // R4
      HFR_OFS_FIELD_STRENGTH: rd_data = mag_ff; // R7
      default: rd_data = HFR_UNMAPPED_DATA;
    endcase
  end

  always_comb begin
    sclk_rise = sclk_s2_ff && !sclk_s3_ff;
    sclk_fall = !sclk_s2_ff && sclk_s3_ff;
    nxt_cnt = cnt_ff;
    nxt_cmd = cmd_ff;
    nxt_tx = tx_ff;
    nxt_rd = rd_ff;
    nxt_miso = miso_ff;
    nxt_oe_n = oe_n_ff;
    if (cs_s2_ff) begin
      nxt_cnt = '0; // R9
      nxt_rd = 1'b0;
      nxt_miso = 1'b0;
      nxt_oe_n = 1'b1; // R9
    end else if (sclk_rise) begin
      if (cnt_ff < HFR_CNT_W'(HFR_CMD_W)) begin
        nxt_cmd = {cmd_ff[HFR_CMD_W-2:0], mosi_s2_ff}; // R9
      end
      if (cnt_ff < HFR_CNT_W'(HFR_FRAME_W)) begin
        nxt_cnt = cnt_ff + HFR_CNT_W'(1);
      end
      if (cnt_ff == HFR_CNT_W'(HFR_CMD_W - 1)) begin
        // whole word latched here so a commit cannot tear the read
        nxt_rd = nxt_cmd[HFR_READ_BIT];
        nxt_tx = nxt_cmd[HFR_READ_BIT] ? rd_data : HFR_UNMAPPED_DATA;
      end
    end else if (sclk_fall && rd_ff && cnt_ff >= HFR_CNT_W'(HFR_CMD_W)
                 && cnt_ff < HFR_CNT_W'(HFR_FRAME_W)) begin
      nxt_miso = tx_ff[15]; // R9
      nxt_tx = {tx_ff[14:0], 1'b0};
      nxt_oe_n = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      mosi_s1_ff <= 1'b0;
      mosi_s2_ff <= 1'b0;
      cnt_ff <= '0;
      cmd_ff <= '0;
      tx_ff <= HFR_UNMAPPED_DATA;
      rd_ff <= 1'b0;
      miso_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      sclk_s1_ff <= SPI_SCLK;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      cs_s1_ff <= SPI_CS_N;
      cs_s2_ff <= cs_s1_ff;
      mosi_s1_ff <= SPI_MOSI;
      mosi_s2_ff <= mosi_s1_ff;
      cnt_ff <= nxt_cnt;
      cmd_ff <= nxt_cmd;
      tx_ff <= nxt_tx;
      rd_ff <= nxt_rd;
      miso_ff <= nxt_miso;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign SPI_MISO = miso_ff;
  assign SPI_MISO_OE_N = oe_n_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic addr_phase_end;
  assign addr_phase_end = !cs_s2_ff && sclk_rise && cnt_ff == HFR_CNT_W'(HFR_CMD_W - 1)
                          && nxt_cmd[HFR_READ_BIT];

  chk_read_z_one: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R1
    (addr_phase_end && nxt_cmd[9:0] == HFR_OFS_Z_PIXEL_ONE) |=> tx_ff == $past(z1_ff))
    else $error("pixel one z read returned wrong word");
  chk_read_z_zero: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R2
    (addr_phase_end && nxt_cmd[9:0] == HFR_OFS_Z_PIXEL_ZERO) |=> tx_ff == $past(z0_ff))
    else $error("pixel zero z read returned wrong word");
  chk_read_x_one: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R3
    (addr_phase_end && nxt_cmd[9:0] == HFR_OFS_X_PIXEL_ONE) |=> tx_ff == $past(x1_ff))
    else $error("pixel one x read returned wrong word");
  chk_read_x_zero: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R4
    (addr_phase_end && nxt_cmd[9:0] == HFR_OFS_X_PIXEL_ZERO) |=> tx_ff == $past(x0_ff))
    else $error("pixel zero x read returned wrong word");
  chk_read_strength: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R7
    (addr_phase_end && nxt_cmd[9:0] == HFR_OFS_FIELD_STRENGTH) |=> tx_ff == $past(mag_ff))
    else $error("field strength read returned wrong word");
  chk_abs_operands: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R5
    (accept && !DIFFERENTIAL_SELECT) |=> start_ff && op_y == ext($past(Z_PIXEL_ONE)))
    else $error("absolute mode did not use pixel one z");
  chk_diff_operands: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R6
    (accept && DIFFERENTIAL_SELECT) |=>
    op_x == ext($past(X_PIXEL_ZERO)) - ext($past(X_PIXEL_ONE)))
    else $error("differential mode did not use pixel x difference");
  chk_miso_release: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R9
    cs_s2_ff |=> SPI_MISO_OE_N && !rd_ff)
    else $error("data line driven while deselected");
  chk_commit_together: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // R10
    (!$stable(mag_ff) || !$stable(z1_ff) || !$stable(x0_ff)) |-> $past(cor_done) && upd_ff)
    else $error("result register changed outside a commit");

  cov_read_strength: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    addr_phase_end && nxt_cmd[9:0] == HFR_OFS_FIELD_STRENGTH);
  cov_abs_commit: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    cor_done && !pdiff_ff);
  cov_diff_commit: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    cor_done && pdiff_ff);
endmodule
`default_nettype wire

//--- hfr_pkg.sv
// package: register map, frame layout and cordic constants of the hall field readout
`default_nettype none
package hfr_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int HFR_ADDR_W = 10;
  localparam logic [9:0] HFR_OFS_Z_PIXEL_ONE = 10'h111;
  localparam logic [9:0] HFR_OFS_Z_PIXEL_ZERO = 10'h112;
  localparam logic [9:0] HFR_OFS_X_PIXEL_ONE = 10'h113;
  localparam logic [9:0] HFR_OFS_X_PIXEL_ZERO = 10'h114;
  localparam logic [9:0] HFR_OFS_FIELD_STRENGTH = 10'h120;
  localparam int HFR_DATA_W = 16;
  localparam logic [15:0] HFR_RESULT_RST = 16'h0000;
  localparam logic [15:0] HFR_UNMAPPED_DATA = 16'h0000;
  // ------------------------------------------------------------
  // serial frame: 16 command bits, then 16 data bits, msb first
  // ------------------------------------------------------------
  localparam int HFR_CMD_W = 16;
  localparam int HFR_READ_BIT = 15;
  localparam int HFR_ADDR_LSB = 0;
  localparam int HFR_FRAME_W = 32;
  localparam int HFR_CNT_W = 6;
  // ------------------------------------------------------------
  // cordic: gain of 16 rotations is 1.64676, and 0.82338 / 1.64676 = 0.5
  // ------------------------------------------------------------
  localparam int HFR_CORDIC_ITER = 16;
  localparam int HFR_CORDIC_W = 21;
  localparam int HFR_MAG_SHIFT = 1;
  typedef enum logic [2:0] {
    HFR_CS_IDLE = 3'b001,
    HFR_CS_ROT = 3'b010,
    HFR_CS_DONE = 3'b100
  } hfr_cordic_state_t;
endpackage
`default_nettype wire

//--- hfr_cordic.sv
// iterative vectoring cordic returning the scaled field strength
`default_nettype none
module hfr_cordic
  import hfr_pkg::*;
#(
  parameter int W = HFR_CORDIC_W,
  parameter int ITER = HFR_CORDIC_ITER
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic signed [W-1:0] vec_x,
  input wire logic signed [W-1:0] vec_y,
  output logic idle,
  output logic done,
  output logic [15:0] mag
);
  localparam int IW = $clog2(ITER);

  hfr_cordic_state_t state_ff, nxt_state;
  logic signed [W-1:0] x_ff, nxt_x, y_ff, nxt_y, scaled;
  logic [IW-1:0] i_ff, nxt_i;

  // ------------------------------------------------------------
  // rotation engine
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_x = x_ff;
    nxt_y = y_ff;
    nxt_i = i_ff;
    unique case (state_ff)
      HFR_CS_IDLE: begin
        if (start) begin
          // fold into right half plane; magnitude is unchanged
          nxt_x = (vec_x < 0) ? -vec_x : vec_x;
          nxt_y = vec_y;
          nxt_i = '0;
          nxt_state = HFR_CS_ROT;
        end
      end
      HFR_CS_ROT: begin
        if (y_ff >= 0) begin
          nxt_x = x_ff + (y_ff >>> i_ff);
          nxt_y = y_ff - (x_ff >>> i_ff);
        end else begin
          nxt_x = x_ff - (y_ff >>> i_ff);
          nxt_y = y_ff + (x_ff >>> i_ff);
        end
        nxt_i = i_ff + IW'(1);
        if (i_ff == IW'(ITER - 1)) begin
          nxt_state = HFR_CS_DONE;
        end
      end
      HFR_CS_DONE: begin
        nxt_state = HFR_CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= HFR_CS_IDLE;
      x_ff <= '0;
      y_ff <= '0;
      i_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      x_ff <= nxt_x;
      y_ff <= nxt_y;
      i_ff <= nxt_i;
    end
  end

  // halving the gain gives exactly the 0.82338 scale; saturate at full scale
  always_comb begin
    scaled = x_ff >>> HFR_MAG_SHIFT;
    mag = (scaled[W-1:16] != '0) ? 16'hffff : scaled[15:0];
  end

  assign idle = (state_ff == HFR_CS_IDLE);
  assign done = (state_ff == HFR_CS_DONE);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  int abs_x_ff, abs_y_ff, max_ab, sum_ab;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abs_x_ff <= 0;
      abs_y_ff <= 0;
    end else if (start && idle) begin
      abs_x_ff <= (vec_x < 0) ? -int'(vec_x) : int'(vec_x);
      abs_y_ff <= (vec_y < 0) ? -int'(vec_y) : int'(vec_y);
    end
  end
  always_comb begin
    max_ab = (abs_x_ff > abs_y_ff) ? abs_x_ff : abs_y_ff;
    sum_ab = abs_x_ff + abs_y_ff;
  end

  chk_cordic_latency: assert property ( // R5
    @(posedge clk) disable iff (!rst_n) (start && idle) |-> !done [*8] ##10 done)
    else $error("cordic result not ready 17 cycles after start");
  chk_mag_lower: assert property ( // R5
    @(posedge clk) disable iff (!rst_n)
    (done && mag != 16'hffff) |-> (int'(mag) * 100 + 200 >= max_ab * 82))
    else $error("field strength below 0.82338 of larger component");
  chk_mag_upper: assert property ( // R6
    @(posedge clk) disable iff (!rst_n) done |-> (int'(mag) * 100 <= sum_ab * 83 + 200))
    else $error("field strength above 0.82338 of component sum");
endmodule
`default_nettype wire

//--- hfr_spi_host.sv
// spi host model: mode 0 controller issuing 32-bit command/data frames
`default_nettype none
module hfr_spi_host (
  input wire logic clk,
  input wire logic miso,
  input wire logic miso_oe_n,
  output var logic sclk,
  output var logic cs_n,
  output var logic mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_bit = 1'b0;
  logic wire_miso;
  // ------------------------------------------------------------
  // released line shows the inverse of its last value, no pull
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (miso_oe_n === 1'b0) begin
      last_bit <= miso;
    end
  end
  assign wire_miso = (miso_oe_n === 1'b0) ? miso : ~last_bit;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // 8 core cycles per phase, above the 6-cycle minimum
  task automatic half_phase();
    repeat (8) @(posedge clk);
    #1;
  endtask
  // one frame, four wires, device as peripheral; host samples on rises 17..32
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rd,
                      output logic [5:0] drv_cnt);
    rd = 16'h0000;
    drv_cnt = 6'h00;
    cs_n = 1'b0;
    half_phase();
    for (int i = 0; i < 32; i++) begin
      mosi = (i < 16) ? cmd[15-i] : 1'b0;
      half_phase();
      sclk = 1'b1;
      if (i >= 16) begin
        rd[31-i] = wire_miso;
        drv_cnt = drv_cnt + ((miso_oe_n === 1'b0) ? 6'h01 : 6'h00);
      end
      half_phase();
      sclk = 1'b0;
    end
    half_phase();
    cs_n = 1'b1;
    mosi = 1'b0;
    half_phase();
  endtask
endmodule
`default_nettype wire

//--- tb_hall_field_readout.sv
// self-checking bench of the hall field readout
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin $display("[ERR] %s expected %h seen %h", nm, ex, got); err_count++; end end
module tb_hall_field_readout
  import hfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe_n, result_update;
  logic sample_valid = 1'b0;
  logic dsel = 1'b0;
  logic [15:0] z0 = 16'h0000, x0 = 16'h0000, z1 = 16'h0000, x1 = 16'h0000;
  int err_count = 0;
  int samples_checked = 0;
  always #10 core_clk = ~core_clk;
  hall_field_readout i_dut (.CORE_CLK(core_clk), .RESET_N(reset_n), .SPI_SCLK(sclk),
    .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE_N(miso_oe_n),
    .SAMPLE_VALID(sample_valid), .Z_PIXEL_ZERO(z0), .X_PIXEL_ZERO(x0),
    .Z_PIXEL_ONE(z1), .X_PIXEL_ONE(x1), .DIFFERENTIAL_SELECT(dsel),
    .RESULT_UPDATE(result_update));
  hfr_spi_host i_host (.clk(core_clk), .miso(miso), .miso_oe_n(miso_oe_n), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check_reg(input logic [9:0] addr, input logic [15:0] ex);
    logic [15:0] rd;
    logic [5:0] cnt;
    i_host.xfer({1'b1, 5'h00, addr}, rd, cnt);
    `CHK("read data", ex, rd)
    `CHK("driven bits", 6'h10, cnt)
  endtask
  // sample taken at the edge after the pulse; optional second pulse while busy
  task automatic convert(input logic intrude);
    int n;
    sample_valid = 1'b1;
    @(posedge core_clk);
    #1;
    sample_valid = 1'b0;
    n = 0;
    while (n < 40 && result_update !== 1'b1) begin
      if (intrude && n == 5) begin
        {z0, x0, z1, x1} = {16'h7fff, 16'h7fff, 16'h0001, 16'h0001};
        sample_valid = 1'b1;
      end else begin
        sample_valid = 1'b0;
      end
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK("update delay", 32'd18, n)
    @(posedge core_clk);
    #1;
    `CHK("update pulse width", 1'b0, result_update)
  endtask
  task automatic check_mag(input real a, input real b);
    logic [15:0] rd, lo, hi;
    logic [5:0] cnt;
    int ex;
    ex = int'($floor(0.82338 * $sqrt(a * a + b * b)));
    lo = 16'(ex - 2);
    hi = 16'(ex + 2);
    i_host.xfer({1'b1, 5'h00, HFR_OFS_FIELD_STRENGTH}, rd, cnt);
    `CHK("strength in range", 1'b1, (rd >= lo && rd <= hi))
    `CHK("strength weak", 1'b0, (rd < 16'h0100))
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check_reg(HFR_OFS_Z_PIXEL_ONE, 16'h0000);
    check_reg(HFR_OFS_Z_PIXEL_ZERO, 16'h0000);
    check_reg(HFR_OFS_X_PIXEL_ONE, 16'h0000);
    check_reg(HFR_OFS_X_PIXEL_ZERO, 16'h0000);
    check_reg(HFR_OFS_FIELD_STRENGTH, 16'h0000);
  endtask
  task automatic t_absolute();
    {z0, x0, z1, x1} = {16'h1234, 16'h4321, 16'h0bb8, 16'h0fa0};
    dsel = 1'b0;
    convert(1'b0);
    check_reg(HFR_OFS_Z_PIXEL_ONE, 16'h0bb8);
    check_reg(HFR_OFS_Z_PIXEL_ZERO, 16'h1234);
    check_reg(HFR_OFS_X_PIXEL_ONE, 16'h0fa0);
    check_reg(HFR_OFS_X_PIXEL_ZERO, 16'h4321);
    check_mag(3000.0, 4000.0);
  endtask
  // pixel one z negative; busy-time sample must not replace any result
  task automatic t_differential();
    {z0, x0, z1, x1} = {16'h0064, 16'h0384, 16'hfd44, 16'h0064};
    dsel = 1'b1;
    convert(1'b1);
    check_reg(HFR_OFS_Z_PIXEL_ONE, 16'hfd44);
    check_reg(HFR_OFS_Z_PIXEL_ZERO, 16'h0064);
    check_reg(HFR_OFS_X_PIXEL_ONE, 16'h0064);
    check_reg(HFR_OFS_X_PIXEL_ZERO, 16'h0384);
    check_mag(800.0, 800.0);
  endtask
  // a write to a read-only place is ignored, an unmapped read answers zero
  task automatic t_refused();
    logic [15:0] rd;
    logic [5:0] cnt;
    i_host.xfer({1'b0, 5'h00, HFR_OFS_Z_PIXEL_ONE}, rd, cnt);
    `CHK("write left undriven", 6'h00, cnt)
    check_reg(HFR_OFS_Z_PIXEL_ONE, 16'hfd44);
    check_reg(10'h115, HFR_UNMAPPED_DATA);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    t_reset();
    t_absolute();
    t_differential();
    t_refused();
    give_verdict();
  end
  // about 18 frames of 536 cycles each, under 200 us; limit is twice that
  initial begin
    #400us;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
